// File: rtl/rtcc_top.v
// Calendar shadow registers, subsecond readout, combined interrupt and low-power wake logic
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defs.vh"

module rtcc_top (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Register port
    input  wire [7:0]  addr,
    input  wire [7:0]  wr_data,
    input  wire        wr_en,
    input  wire        rd_en,
    output reg  [7:0]  rd_data,
    // Calendar timing from the prescaler
    input  wire        calendar_clock_tick,
    input  wire        second_tick,
    input  wire [15:0] sync_prescaler_count,
    // Event sources
    input  wire        alarm_event,
    input  wire        wakeup_event,
    input  wire [2:0]  tamper_event,
    // Power mode and clock source
    input  wire        wait_mode,
    input  wire        halt_mode,
    input  wire        low_speed_external_osc,
    input  wire        low_speed_internal_osc,
    // Interrupt and wake outputs
    output reg         irq,
    output reg         wake_from_wait,
    output reg         wake_from_halt
);

    // ****************************************
    // Decoding helpers
    // ****************************************

    // BCD increment of a two-digit value
    function [7:0] bcd_inc;
        input [7:0] v;
        begin
            if (v[3:0] == 4'h9) begin
                bcd_inc = {v[7:4] + 4'h1, 4'h0};
            end else begin
                bcd_inc = {v[7:4], v[3:0] + 4'h1};
            end
        end
    endfunction

    // Last day of a month, leap years taken from the BCD year
    function [7:0] month_last_day;
        input [7:0] month;
        input [7:0] year;
        reg   [1:0] yr_mod4;
        begin
            // Tens weigh 10, which is 2 mod 4
            yr_mod4 = year[1:0] + {year[4], 1'b0};
            case (month)
                8'h02:   month_last_day = (yr_mod4 == 2'h0) ? 8'h29 : 8'h28;
                8'h04,
                8'h06,
                8'h09,
                8'h11:   month_last_day = 8'h30;
                default: month_last_day = 8'h31;
            endcase
        end
    endfunction

    // Calendar registers that need init mode and unlock to be written
    function is_calendar_ofs;
        input [7:0] a;
        begin
            is_calendar_ofs = (a == `RTCC_OFS_SECONDS) || (a == `RTCC_OFS_MINUTES) ||
                              (a == `RTCC_OFS_HOURS) || (a == `RTCC_OFS_DAY) ||
                              (a == `RTCC_OFS_MONTH_WDAY) || (a == `RTCC_OFS_YEAR);
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    reg [7:0]  sec_reg;
    reg [7:0]  min_reg;
    reg [7:0]  hour_reg;
    reg [7:0]  day_reg;
    reg [7:0]  month_wday_reg;
    reg [7:0]  year_reg;
    reg [7:0]  sh_sec_reg;
    reg [7:0]  sh_min_reg;
    reg [7:0]  sh_hour_reg;
    reg [7:0]  sh_day_reg;
    reg [7:0]  sh_month_wday_reg;
    reg [7:0]  sh_year_reg;
    reg [15:0] sh_subsec_reg;
    reg        bypass_reg;
    reg        alarm_ie_reg;
    reg        wake_ie_reg;
    reg        tamp_ie_reg;
    reg        init_req_reg;
    reg        init_flag_reg;
    reg        sync_flag_reg;
    reg        alarm_flag_reg;
    reg        wake_flag_reg;
    reg [2:0]  tamp_flag_reg;
    reg [1:0]  key_state_reg;

    localparam [1:0] KEY_LOCKED   = 2'h0;
    localparam [1:0] KEY_HALF     = 2'h1;
    localparam [1:0] KEY_UNLOCKED = 2'h2;

    wire unlocked = (key_state_reg == KEY_UNLOCKED);
    wire low_speed_src = low_speed_external_osc | low_speed_internal_osc;

    // ****************************************
    // Write decode
    // ****************************************
    // Protected writes are dropped silently; software sees no error
    wire prot_ok   = wr_en & unlocked;
    wire cal_wr    = prot_ok & init_flag_reg & is_calendar_ofs(addr);
    wire ctrl_wr   = prot_ok & (addr == `RTCC_OFS_CTRL);
    wire ie_wr     = prot_ok & (addr == `RTCC_OFS_IRQ_EN);
    wire init_wr   = prot_ok & (addr == `RTCC_OFS_INIT_STAT);
    wire tctrl_wr  = prot_ok & (addr == `RTCC_OFS_TAMP_CTRL);
    wire evt_wr    = wr_en & (addr == `RTCC_OFS_EVT_FLAGS);
    wire tflag_wr  = wr_en & (addr == `RTCC_OFS_TAMP_FLAGS);
    wire key_wr    = wr_en & (addr == `RTCC_OFS_WPROT_KEY);

    // ****************************************
    // Write protection key sequence
    // ****************************************
    // Any other value on the key register locks again
    always @(posedge clk) begin
        if (rst) begin
            key_state_reg <= KEY_LOCKED;
        end else if (key_wr) begin
            case (key_state_reg)
                KEY_LOCKED:
                    key_state_reg <= (wr_data == `RTCC_KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
                KEY_HALF:
                    key_state_reg <= (wr_data == `RTCC_KEY_SECOND) ? KEY_UNLOCKED : KEY_LOCKED;
                default:
                    key_state_reg <= KEY_LOCKED;
            endcase
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    always @(posedge clk) begin
        if (rst) begin
            bypass_reg   <= 1'b0;
            alarm_ie_reg <= 1'b0;
            wake_ie_reg  <= 1'b0;
            tamp_ie_reg  <= 1'b0;
            init_req_reg <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                bypass_reg <= wr_data[`RTCC_BIT_BYPASS];
            end
            if (ie_wr) begin
                alarm_ie_reg <= wr_data[`RTCC_BIT_ALARM_IE];
                wake_ie_reg  <= wr_data[`RTCC_BIT_WAKE_IE];
            end
            if (tctrl_wr) begin
                tamp_ie_reg <= wr_data[`RTCC_BIT_TAMP_IE];
            end
            if (init_wr) begin
                init_req_reg <= wr_data[`RTCC_BIT_INIT_REQ];
            end
        end
    end

    // Init flag follows the request one cycle later
    always @(posedge clk) begin
        if (rst) begin
            init_flag_reg <= 1'b0;
        end else begin
            init_flag_reg <= init_req_reg;
        end
    end

    // ****************************************
    // Calendar counters
    // ****************************************
    // Halt stops the count unless a low-speed oscillator drives the block
    wire count_clock_ok = ~halt_mode | low_speed_src;
    wire count_tick     = second_tick & count_clock_ok & ~init_req_reg & ~init_flag_reg;

    wire       sec_wrap  = (sec_reg == `RTCC_MAX_SEC_MIN);
    wire       min_wrap  = (min_reg == `RTCC_MAX_SEC_MIN);
    wire [7:0] hour_bcd  = hour_reg & `RTCC_MASK_HOUR_BCD;
    wire       hour_wrap = (hour_bcd == `RTCC_MAX_HOUR);
    wire [7:0] month_bcd = month_wday_reg & `RTCC_MASK_MONTH;
    wire [2:0] wday      = month_wday_reg[`RTCC_WDAY_HI:`RTCC_WDAY_LO];
    wire       day_wrap  = (day_reg == month_last_day(month_bcd, year_reg));
    wire       mon_wrap  = (month_bcd == `RTCC_MAX_MONTH);
    wire [2:0] wday_next = (wday == `RTCC_WDAY_SUNDAY) ? `RTCC_WDAY_MONDAY : wday + 3'h1;
    wire [7:0] mon_next  = mon_wrap ? `RTCC_FIRST_MONTH : bcd_inc(month_bcd);
    wire [7:0] year_next = (year_reg == `RTCC_MAX_YEAR) ? `RTCC_ZERO_BCD : bcd_inc(year_reg);

    // Counting and init-mode writes; counters hold whenever init is active
    always @(posedge clk) begin
        if (rst) begin
            sec_reg        <= `RTCC_RST_SECONDS;
            min_reg        <= `RTCC_RST_MINUTES;
            hour_reg       <= `RTCC_RST_HOURS;
            day_reg        <= `RTCC_RST_DAY;
            month_wday_reg <= `RTCC_RST_MONTH_WDAY;
            year_reg       <= `RTCC_RST_YEAR;
        end else if (cal_wr) begin
            case (addr)
                `RTCC_OFS_SECONDS:    sec_reg        <= wr_data & `RTCC_MASK_SECONDS;
                `RTCC_OFS_MINUTES:    min_reg        <= wr_data & `RTCC_MASK_MINUTES;
                `RTCC_OFS_HOURS:      hour_reg       <= wr_data & `RTCC_MASK_HOURS;
                `RTCC_OFS_DAY:        day_reg        <= wr_data & `RTCC_MASK_DAY;
                `RTCC_OFS_MONTH_WDAY: month_wday_reg <= wr_data;
                `RTCC_OFS_YEAR:       year_reg       <= wr_data;
                default:              sec_reg        <= sec_reg;
            endcase
        end else if (count_tick) begin
            sec_reg <= sec_wrap ? `RTCC_ZERO_BCD : bcd_inc(sec_reg);
            if (sec_wrap) begin
                min_reg <= min_wrap ? `RTCC_ZERO_BCD : bcd_inc(min_reg);
                if (min_wrap) begin
                    // Afternoon flag is kept as software wrote it
                    hour_reg <= {hour_reg[7:6], 6'h00} |
                                (hour_wrap ? `RTCC_ZERO_BCD : bcd_inc(hour_bcd));
                    if (hour_wrap) begin
                        day_reg <= day_wrap ? `RTCC_FIRST_DAY : bcd_inc(day_reg);
                        month_wday_reg[`RTCC_WDAY_HI:`RTCC_WDAY_LO] <= wday_next;
                        if (day_wrap) begin
                            month_wday_reg[4:0] <= mon_next[4:0];
                            if (mon_wrap) begin
                                year_reg <= year_next;
                            end
                        end
                    end
                end
            end
        end
    end

    // ****************************************
    // Shadow copies
    // ****************************************
    // Refreshed once per calendar clock cycle so a multi-byte read stays coherent
    always @(posedge clk) begin
        if (rst) begin
            sh_sec_reg        <= `RTCC_RST_SECONDS;
            sh_min_reg        <= `RTCC_RST_MINUTES;
            sh_hour_reg       <= `RTCC_RST_HOURS;
            sh_day_reg        <= `RTCC_RST_DAY;
            sh_month_wday_reg <= `RTCC_RST_MONTH_WDAY;
            sh_year_reg       <= `RTCC_RST_YEAR;
            sh_subsec_reg     <= `RTCC_RST_SUBSEC;
        end else if (calendar_clock_tick) begin
            sh_sec_reg        <= sec_reg;
            sh_min_reg        <= min_reg;
            sh_hour_reg       <= hour_reg;
            sh_day_reg        <= day_reg;
            sh_month_wday_reg <= month_wday_reg;
            sh_year_reg       <= year_reg;
            // Count passed through as is; software handles the post-shift case
            sh_subsec_reg     <= sync_prescaler_count;
        end
    end

    // Sync flag: set by copy, cleared by software writing 0 or by init
    always @(posedge clk) begin
        if (rst) begin
            sync_flag_reg <= 1'b0;
        end else if (init_flag_reg) begin
            sync_flag_reg <= 1'b0;
        end else if (calendar_clock_tick) begin
            sync_flag_reg <= 1'b1;
        end else if (init_wr & ~wr_data[`RTCC_BIT_SYNC_FLAG]) begin
            sync_flag_reg <= 1'b0;
        end
    end

    // ****************************************
    // Event flags
    // ****************************************
    // Write 0 clears; a new event in the same cycle wins over the clear
    always @(posedge clk) begin
        if (rst) begin
            alarm_flag_reg <= 1'b0;
            wake_flag_reg  <= 1'b0;
        end else begin
            if (alarm_event) begin
                alarm_flag_reg <= 1'b1;
            end else if (evt_wr & ~wr_data[`RTCC_BIT_ALARM_F]) begin
                alarm_flag_reg <= 1'b0;
            end
            if (wakeup_event) begin
                wake_flag_reg <= 1'b1;
            end else if (evt_wr & ~wr_data[`RTCC_BIT_WAKE_F]) begin
                wake_flag_reg <= 1'b0;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_tamp
            // One sticky flag per tamper input
            always @(posedge clk) begin
                if (rst) begin
                    tamp_flag_reg[gi] <= 1'b0;
                end else if (tamper_event[gi]) begin
                    tamp_flag_reg[gi] <= 1'b1;
                end else if (tflag_wr & ~wr_data[gi]) begin
                    tamp_flag_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ****************************************
    // Interrupt request and wake
    // ****************************************
    wire irq_next = (alarm_flag_reg & alarm_ie_reg) |
                    (wake_flag_reg & wake_ie_reg) |
                    ((|tamp_flag_reg) & tamp_ie_reg);

    // Wait wake needs nothing more; halt wake needs a low-speed source
    always @(posedge clk) begin
        if (rst) begin
            irq            <= 1'b0;
            wake_from_wait <= 1'b0;
            wake_from_halt <= 1'b0;
        end else begin
            irq            <= irq_next;
            wake_from_wait <= irq_next & wait_mode;
            wake_from_halt <= irq_next & halt_mode & low_speed_src;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    reg [7:0] rd_next;

    // Bypass picks live counters; otherwise the shadow copies
    always @* begin
        rd_next = 8'h00;
        case (addr)
            `RTCC_OFS_SECONDS:    rd_next = (bypass_reg ? sec_reg : sh_sec_reg) & `RTCC_MASK_SECONDS;
            `RTCC_OFS_MINUTES:    rd_next = (bypass_reg ? min_reg : sh_min_reg) & `RTCC_MASK_MINUTES;
            `RTCC_OFS_HOURS:      rd_next = (bypass_reg ? hour_reg : sh_hour_reg) & `RTCC_MASK_HOURS;
            `RTCC_OFS_DAY:        rd_next = (bypass_reg ? day_reg : sh_day_reg) & `RTCC_MASK_DAY;
            `RTCC_OFS_MONTH_WDAY: rd_next = bypass_reg ? month_wday_reg : sh_month_wday_reg;
            `RTCC_OFS_YEAR:       rd_next = bypass_reg ? year_reg : sh_year_reg;
            `RTCC_OFS_SUBSEC_HI:  rd_next = bypass_reg ? sync_prescaler_count[15:8]
                                                       : sh_subsec_reg[15:8];
            `RTCC_OFS_SUBSEC_LO:  rd_next = bypass_reg ? sync_prescaler_count[7:0]
                                                       : sh_subsec_reg[7:0];
            `RTCC_OFS_CTRL:       rd_next[`RTCC_BIT_BYPASS] = bypass_reg;
            `RTCC_OFS_IRQ_EN: begin
                rd_next[`RTCC_BIT_ALARM_IE] = alarm_ie_reg;
                rd_next[`RTCC_BIT_WAKE_IE]  = wake_ie_reg;
            end
            `RTCC_OFS_INIT_STAT: begin
                rd_next[`RTCC_BIT_INIT_REQ]  = init_req_reg;
                rd_next[`RTCC_BIT_INIT_FLAG] = init_flag_reg;
                rd_next[`RTCC_BIT_SYNC_FLAG] = sync_flag_reg;
            end
            `RTCC_OFS_EVT_FLAGS: begin
                rd_next[`RTCC_BIT_ALARM_F] = alarm_flag_reg;
                rd_next[`RTCC_BIT_WAKE_F]  = wake_flag_reg;
            end
            `RTCC_OFS_TAMP_FLAGS: rd_next[2:0] = tamp_flag_reg;
            `RTCC_OFS_TAMP_CTRL:  rd_next[`RTCC_BIT_TAMP_IE] = tamp_ie_reg;
            default:              rd_next = 8'h00;
        endcase
    end

    // Data stand one cycle after the strobe and read zero otherwise
    always @(posedge clk) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_en ? rd_next : 8'h00;
        end
    end

endmodule
`default_nettype wire

// File: rtl/rtcc_defs.vh
// Offsets, field positions, reset values and keys of the calendar register block
`ifndef RTCC_DEFS_VH
`define RTCC_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define RTCC_OFS_SECONDS     8'h00
`define RTCC_OFS_MINUTES     8'h01
`define RTCC_OFS_HOURS       8'h02
`define RTCC_OFS_DAY         8'h04
`define RTCC_OFS_MONTH_WDAY  8'h05
`define RTCC_OFS_YEAR        8'h06
`define RTCC_OFS_CTRL        8'h08
`define RTCC_OFS_IRQ_EN      8'h09
`define RTCC_OFS_INIT_STAT   8'h0c
`define RTCC_OFS_EVT_FLAGS   8'h0d
`define RTCC_OFS_TAMP_FLAGS  8'h0e
`define RTCC_OFS_TAMP_CTRL   8'h0f
`define RTCC_OFS_WPROT_KEY   8'h10
`define RTCC_OFS_SUBSEC_HI   8'h17
`define RTCC_OFS_SUBSEC_LO   8'h18

// ****************************************
// Field masks and bit positions
// ****************************************
`define RTCC_MASK_SECONDS    8'h7f
`define RTCC_MASK_MINUTES    8'h7f
`define RTCC_MASK_HOURS      8'h7f
`define RTCC_MASK_DAY        8'h3f
`define RTCC_MASK_MONTH      8'h1f
`define RTCC_MASK_HOUR_BCD   8'h3f
`define RTCC_BIT_AFTERNOON   6
`define RTCC_BIT_BYPASS      4
`define RTCC_BIT_WAKE_IE     6
`define RTCC_BIT_ALARM_IE    4
`define RTCC_BIT_INIT_REQ    7
`define RTCC_BIT_INIT_FLAG   6
`define RTCC_BIT_SYNC_FLAG   5
`define RTCC_BIT_ALARM_F     0
`define RTCC_BIT_WAKE_F      2
`define RTCC_BIT_TAMP_IE     0
`define RTCC_WDAY_HI         7
`define RTCC_WDAY_LO         5

// ****************************************
// Reset values
// ****************************************
`define RTCC_RST_SECONDS     8'h00
`define RTCC_RST_MINUTES     8'h00
`define RTCC_RST_HOURS       8'h00
`define RTCC_RST_DAY         8'h01
`define RTCC_RST_MONTH_WDAY  8'h21
`define RTCC_RST_YEAR        8'h00
`define RTCC_RST_SUBSEC      16'h0000

// ****************************************
// Calendar limits and write-protect keys
// ****************************************
`define RTCC_MAX_SEC_MIN     8'h59
`define RTCC_MAX_HOUR        8'h23
`define RTCC_MAX_MONTH       8'h12
`define RTCC_MAX_YEAR        8'h99
`define RTCC_FIRST_DAY       8'h01
`define RTCC_FIRST_MONTH     8'h01
`define RTCC_ZERO_BCD        8'h00
`define RTCC_WDAY_MONDAY     3'h1
`define RTCC_WDAY_SUNDAY     3'h7
`define RTCC_KEY_FIRST       8'hca
`define RTCC_KEY_SECOND      8'h53

`endif

// File: dv/rtcc_props.sv
// Port-level checker for the calendar register block
`timescale 1ns/1ps
`default_nettype none
module rtcc_props (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rd_data,
    // Events, power mode, outputs
    input wire logic       alarm_event,
    input wire logic       wakeup_event,
    input wire logic [2:0] tamper_event,
    input wire logic       wait_mode,
    input wire logic       halt_mode,
    input wire logic       low_speed_external_osc,
    input wire logic       low_speed_internal_osc,
    input wire logic       irq,
    input wire logic       wake_from_wait,
    input wire logic       wake_from_halt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ****************************************
    // Reserved bits and field codes on reads
    // ****************************************
    AST_SEC_BIT7: assert property ($past(rd_en && addr == 8'h00) |-> !rd_data[7])
        else $error("seconds bit 7 read as one");
    AST_MIN_BIT7: assert property ($past(rd_en && addr == 8'h01) |-> !rd_data[7])
        else $error("minutes bit 7 read as one");
    AST_HOUR_BIT7: assert property ($past(rd_en && addr == 8'h02) |-> !rd_data[7])
        else $error("hours bit 7 read as one");
    AST_DAY_RSVD: assert property ($past(rd_en && addr == 8'h04) |-> rd_data[7:6] == 2'h0)
        else $error("day reserved bits read nonzero");
    AST_WDAY_CODE: assert property ($past(rd_en && addr == 8'h05) |-> rd_data[7:5] != 3'h0)
        else $error("weekday code zero");
    // ****************************************
    // Shared request and wake outputs
    // ****************************************
    // Wake terms share the registered request, so they follow the mode of the previous cycle
    AST_WAIT_WAKE: assert property (wake_from_wait == (irq && $past(wait_mode)))
        else $error("wait wake disagrees with request");
    AST_HALT_WAKE: assert property (wake_from_halt == (irq && $past(halt_mode &&
        (low_speed_external_osc || low_speed_internal_osc))))
        else $error("halt wake disagrees with request and clock source");
    AST_IRQ_RISE: assert property ($rose(irq) |-> $past(wr_en, 2) ||
        $past(alarm_event || wakeup_event || (|tamper_event), 2))
        else $error("request rose without cause");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_en, 2))
        else $error("request fell without software write");
    COV_IRQ: cover property ($rose(irq));
    COV_WAIT: cover property (wake_from_wait);
    COV_HALT: cover property (wake_from_halt);
endmodule
`default_nettype wire

// File: dv/rtcc_top_tb.sv
// Self-checking bench for the calendar register block
`timescale 1ns/1ps
`default_nettype none
module rtcc_top_tb;
    logic        clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic [7:0]  addr = 8'h00, wr_data = 8'h00, rd_data, v;
    logic        cal_tick = 1'b0, sec_tick = 1'b0, alarm_ev = 1'b0, wake_ev = 1'b0;
    logic [15:0] ss_count = 16'h0000;
    logic [2:0]  tamp_ev = 3'h0;
    logic        wait_m = 1'b0, halt_m = 1'b0, ext_osc = 1'b0, int_osc = 1'b0;
    logic        irq, wake_w, wake_h;
    int          mismatches = 0, checks = 0, cycles = 0, k;
    logic [7:0]  rst_adr [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h17, 8'h18};
    logic [7:0]  rst_val [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h21, 8'h00, 8'h00, 8'h00};
    rtcc_top i_rtcc_top (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .calendar_clock_tick(cal_tick),
        .second_tick(sec_tick), .sync_prescaler_count(ss_count), .alarm_event(alarm_ev),
        .wakeup_event(wake_ev), .tamper_event(tamp_ev), .wait_mode(wait_m),
        .halt_mode(halt_m), .low_speed_external_osc(ext_osc), .low_speed_internal_osc(int_osc),
        .irq(irq), .wake_from_wait(wake_w), .wake_from_halt(wake_h));
    always #12.5 clk = ~clk;
    // ****************************************
    // Bus tasks and comparison
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1; addr <= a; wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd_en <= 1'b1; addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk($sformatf("reg %h", a), d, exp);
    endtask
    // Shadow refresh and second advance pulses
    task automatic tick(input bit second);
        @(posedge clk);
        if (second) sec_tick <= 1'b1; else cal_tick <= 1'b1;
        @(posedge clk);
        sec_tick <= 1'b0; cal_tick <= 1'b0;
    endtask
    task automatic conclude;
        if (mismatches == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Hang guard, far above the two hundred or so cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude;
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (k = 0; k < 8; k++) rdchk(rst_adr[k], rst_val[k]);
        wr(8'h00, 8'h12); tick(0); rdchk(8'h00, 8'h00);
        wr(8'h10, 8'hca); wr(8'h10, 8'h53);
        wr(8'h00, 8'h12); tick(0); rdchk(8'h00, 8'h00);
        wr(8'h0c, 8'h80); wr(8'h00, 8'hd9); wr(8'h01, 8'h59); wr(8'h02, 8'h23);
        wr(8'h06, 8'h24);
        tick(1); tick(0); rdchk(8'h00, 8'h59);
        rdchk(8'h01, 8'h59); rdchk(8'h02, 8'h23);
        wr(8'h0c, 8'h00); tick(1); rdchk(8'h00, 8'h59); tick(0);
        rdchk(8'h00, 8'h00); rdchk(8'h01, 8'h00); rdchk(8'h02, 8'h00);
        rdchk(8'h04, 8'h02); rdchk(8'h05, 8'h41); rdchk(8'h06, 8'h24);
        @(posedge clk); ss_count <= 16'hbeef;
        wr(8'h17, 8'h00); wr(8'h18, 8'h00); tick(0);
        rdchk(8'h17, 8'hbe); rdchk(8'h18, 8'hef);
        // Bypass reads the live count while the shadow still holds the old one
        @(posedge clk); ss_count <= 16'h1234;
        wr(8'h08, 8'h10);
        rdchk(8'h17, 8'h12); rdchk(8'h18, 8'h34); wr(8'h08, 8'h00);
        wr(8'h09, 8'h50); wr(8'h0f, 8'h01);
        // Each source alone; external oscillator for the wake source, internal for tamper 0, none for the others
        for (k = 0; k < 5; k++) begin
            @(posedge clk);
            {tamp_ev, wake_ev, alarm_ev} <= 5'h01 << k;
            wait_m <= 1'b1; halt_m <= 1'b1; ext_osc <= (k == 1); int_osc <= (k == 2);
            @(posedge clk);
            {tamp_ev, wake_ev, alarm_ev} <= 5'h00;
            repeat (2) @(posedge clk);
            #1 chk("irq", irq, 8'h01);
            chk("wake wait", wake_w, 8'h01);
            chk("wake halt", wake_h, (k == 1 || k == 2));
            rdchk(8'h0d, {5'h00, k == 1, 1'b0, k == 0});
            rdchk(8'h0e, {5'h00, k == 4, k == 3, k == 2});
            wr(8'h0d, 8'h00); wr(8'h0e, 8'h00);
            @(posedge clk);
            #1 chk("irq clear", irq, 8'h00);
        end
        // Halt with no low-speed source freezes the count; a low-speed source frees it
        tick(1); tick(0); rdchk(8'h00, 8'h00);
        @(posedge clk); int_osc <= 1'b1;
        tick(1); tick(0); rdchk(8'h00, 8'h01);
        wr(8'h09, 8'h00);
        @(posedge clk); alarm_ev <= 1'b1;
        @(posedge clk); alarm_ev <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("irq masked", irq, 8'h00);
        chk("wake masked", wake_w, 8'h00);
        conclude;
    end
endmodule
bind rtcc_top rtcc_props i_rtcc_props (.clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .alarm_event(alarm_event), .wakeup_event(wakeup_event),
    .tamper_event(tamper_event), .wait_mode(wait_mode), .halt_mode(halt_mode),
    .low_speed_external_osc(low_speed_external_osc),
    .low_speed_internal_osc(low_speed_internal_osc), .irq(irq),
    .wake_from_wait(wake_from_wait), .wake_from_halt(wake_from_halt));
`default_nettype wire
